//--- core/rtcw_host_port.sv
// sram style host write port with on-chip register file
// assumes host pins are asynchronous to i_clock and held per the bus timing
module rtcw_host_port
  import rtcw_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_resetn,
  input wire logic i_chip_sel_n,
  input wire logic i_write_n,
  input wire logic i_out_drv_n,
  input wire logic i_sram_pick_n,
  input wire logic [rtcw_pkg::RTCW_ADDR_W-1:0] i_addr,
  input wire logic [rtcw_pkg::RTCW_DATA_W-1:0] i_dq,
  output logic [rtcw_pkg::RTCW_DATA_W-1:0] o_dq,
  output logic o_dq_oe,
  output logic o_sram_sel_n,
  output logic o_contention,
  output rtcw_pkg::rtcw_wr_t o_wr,
  output rtcw_pkg::rtcw_rate_t o_alarm_rate
);
  import rtcw_pkg::*;

  typedef struct packed {
    rtcw_pins_t pins1;
    rtcw_pins_t pins2;
    rtcw_pins_t last;
    logic active;
    logic together;
    logic out_en;
    logic [RTCW_DATA_W-1:0] dq_out;
    logic [RTCW_ADDR_W-1:0] wr_addr;
    logic [RTCW_DATA_W-1:0] hold_data;
    rtcw_wr_t wr;
    logic sram_sel_n;
    logic contention;
    rtcw_rate_t rate;
    logic [RTCW_NREGS-1:0][RTCW_DATA_W-1:0] regs;
  } rtcw_state_t;

  localparam rtcw_state_t RTCW_STATE_RST = '{
    pins1: RTCW_PINS_IDLE,
    pins2: RTCW_PINS_IDLE,
    last: RTCW_PINS_IDLE,
    active: 1'b0,
    together: 1'b0,
    out_en: 1'b0,
    dq_out: RTCW_REG_RST,
    wr_addr: 4'h0,
    hold_data: RTCW_REG_RST,
    wr: '{1'b0, 4'h0, 8'h00},
    sram_sel_n: 1'b1,
    contention: 1'b0,
    rate: RTCW_RATE_YEAR,
    regs: {RTCW_NREGS{RTCW_REG_RST}}
  };

  rtcw_state_t s_r;
  rtcw_state_t s_nxt;
  rtcw_pins_t pins_in;
  rtcw_pins_t p;
  logic act;
  logic [4:0] rpt_bits;
  rtcw_rate_t dec_rate;

  assign pins_in = '{i_chip_sel_n, i_write_n, i_out_drv_n, i_sram_pick_n, i_addr, i_dq};
  assign p = s_r.pins2;

  // repeat bits gathered from the alarm bytes
  assign rpt_bits = {s_r.regs[RTCW_OFS_ADATE][RTCW_RPT5_BIT],
                     s_r.regs[RTCW_OFS_ADATE][RTCW_RPT_HI_BIT],
                     s_r.regs[RTCW_OFS_AHOUR][RTCW_RPT_HI_BIT],
                     s_r.regs[RTCW_OFS_AMIN][RTCW_RPT_HI_BIT],
                     s_r.regs[RTCW_OFS_ASEC][RTCW_RPT_HI_BIT]};

  rtcw_alarm_rate u_rate (
    .i_alarm_repeat_bits(rpt_bits),
    .o_rate(dec_rate)
  );

  assign act = !p.chip_sel_n && !p.write_n;

  always_comb
  begin
    s_nxt = s_r;
    // pins1 is only read by pins2
    s_nxt.pins1 = pins_in;
    s_nxt.pins2 = s_r.pins1;
    s_nxt.last = p;
    s_nxt.active = act;
    s_nxt.wr.strobe = 1'b0;
    // address taken at the later falling edge; host keeps it stable
    if (act && !s_r.active)
    begin
      s_nxt.wr_addr = p.addr;
      s_nxt.together = s_r.last.chip_sel_n && s_r.last.write_n;
    end
    // keep the latest sample; only committed at the end, so no partials
    if (act)
    begin
      s_nxt.hold_data = p.data;
    end
    // end at the earlier rising edge: commit the captured byte
    if (!act && s_r.active)
    begin
      s_nxt.regs[s_r.wr_addr] = s_r.hold_data;
      s_nxt.wr.strobe = 1'b1;
      s_nxt.wr.addr = s_r.wr_addr;
      s_nxt.wr.data = s_r.hold_data;
    end
    if (p.chip_sel_n)
    begin
      s_nxt.together = 1'b0;
    end
    // a low write strobe always drops the drive, whatever output drive says
    s_nxt.out_en = !p.chip_sel_n && !p.out_drv_n && p.write_n
                   && !s_nxt.together;
    s_nxt.dq_out = s_r.regs[p.addr];
    s_nxt.sram_sel_n = !(!p.sram_pick_n && p.chip_sel_n);
    // both selects low is a host fault; flagged, and the sram select is held high
    s_nxt.contention = !p.chip_sel_n && !p.sram_pick_n;
    s_nxt.rate = dec_rate;
  end

  always_ff @(posedge i_clock or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      s_r <= RTCW_STATE_RST;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  assign o_dq = s_r.dq_out;
  assign o_dq_oe = s_r.out_en;
  assign o_sram_sel_n = s_r.sram_sel_n;
  assign o_contention = s_r.contention;
  assign o_wr = s_r.wr;
  assign o_alarm_rate = s_r.rate;

  property p_strobe_needs_write;
    @(posedge i_clock) disable iff (!i_resetn)
    s_r.wr.strobe |-> $past(s_r.active) && !s_r.active;
  endproperty
  a_strobe_needs_write: assert property (p_strobe_needs_write)
    else $error("write strobe without an active write");

  property p_addr_at_start;
    @(posedge i_clock) disable iff (!i_resetn)
    $rose(s_r.active) |-> s_r.wr_addr == $past(s_r.pins2.addr);
  endproperty
  a_addr_at_start: assert property (p_addr_at_start)
    else $error("address not taken at write start");

  property p_end_commits;
    @(posedge i_clock) disable iff (!i_resetn)
    $fell(s_r.active) |-> s_r.wr.strobe && s_r.wr.addr == $past(s_r.wr_addr);
  endproperty
  a_end_commits: assert property (p_end_commits)
    else $error("write end did not commit");

  property p_strobe_kills_drive;
    @(posedge i_clock) disable iff (!i_resetn)
    !s_r.pins2.write_n |=> !s_r.out_en;
  endproperty
  a_strobe_kills_drive: assert property (p_strobe_kills_drive)
    else $error("outputs driven during low write strobe");

  property p_together_quiet;
    @(posedge i_clock) disable iff (!i_resetn)
    s_r.together |-> !s_r.out_en;
  endproperty
  a_together_quiet: assert property (p_together_quiet)
    else $error("outputs driven after simultaneous fall");

  property p_reg_written;
    @(posedge i_clock) disable iff (!i_resetn)
    s_r.wr.strobe |-> s_r.regs[s_r.wr.addr] == s_r.wr.data;
  endproperty
  a_reg_written: assert property (p_reg_written)
    else $error("register not holding written byte");

  property p_sram_route;
    @(posedge i_clock) disable iff (!i_resetn)
    !s_r.pins2.sram_pick_n && s_r.pins2.chip_sel_n |=> !s_r.sram_sel_n;
  endproperty
  a_sram_route: assert property (p_sram_route)
    else $error("sram select not routed");

  property p_rate_decode;
    @(posedge i_clock) disable iff (!i_resetn)
    rpt_bits == RTCW_RPT_SEC |=> s_r.rate == RTCW_RATE_SEC;
  endproperty
  a_rate_decode: assert property (p_rate_decode)
    else $error("all ones not decoded as per second");

  property p_undefined_yearly;
    @(posedge i_clock) disable iff (!i_resetn)
    rpt_bits == 5'h01 |=> s_r.rate == RTCW_RATE_YEAR;
  endproperty
  a_undefined_yearly: assert property (p_undefined_yearly)
    else $error("undefined repeat code not yearly");

  property p_no_partial;
    @(posedge i_clock) disable iff (!i_resetn)
    s_r.active && $past(s_r.active) |-> $stable(s_r.regs);
  endproperty
  a_no_partial: assert property (p_no_partial)
    else $error("register changed mid write");

  property p_commit_data;
    @(posedge i_clock) disable iff (!i_resetn)
    s_r.wr.strobe |-> s_r.wr.data == $past(s_r.hold_data);
  endproperty
  a_commit_data: assert property (p_commit_data)
    else $error("committed byte is not the last sample");

  property p_sram_off;
    @(posedge i_clock) disable iff (!i_resetn)
    !s_r.pins2.chip_sel_n |=> s_r.sram_sel_n;
  endproperty
  a_sram_off: assert property (p_sram_off)
    else $error("sram selected while internal select low");

  property p_drive_on;
    @(posedge i_clock) disable iff (!i_resetn)
    !s_r.pins2.chip_sel_n && !s_r.pins2.out_drv_n && s_r.pins2.write_n && !s_r.together
      |=> s_r.out_en;
  endproperty
  a_drive_on: assert property (p_drive_on)
    else $error("outputs not driven for a plain read");

endmodule

//--- core/rtcw_pkg.sv
// constants and types for the rtc host write port and alarm repeat decode
// assumes one 25 mhz clock; host pins arrive asynchronously
package rtcw_pkg;

  localparam int RTCW_ADDR_W = 4;
  localparam int RTCW_DATA_W = 8;
  localparam int RTCW_NREGS = 16;
  localparam int RTCW_NRPT = 5;

  // alarm byte offsets that carry the repeat bits
  localparam logic [3:0] RTCW_OFS_ASEC = 4'h2;
  localparam logic [3:0] RTCW_OFS_AMIN = 4'h3;
  localparam logic [3:0] RTCW_OFS_AHOUR = 4'h4;
  localparam logic [3:0] RTCW_OFS_ADATE = 4'h5;

  // bit positions inside those bytes
  localparam int RTCW_RPT_HI_BIT = 7;
  localparam int RTCW_RPT5_BIT = 6;

  localparam logic [7:0] RTCW_REG_RST = 8'h00;

  typedef enum logic [2:0] {
    RTCW_RATE_SEC,
    RTCW_RATE_MIN,
    RTCW_RATE_HOUR,
    RTCW_RATE_DAY,
    RTCW_RATE_MONTH,
    RTCW_RATE_YEAR
  } rtcw_rate_t;

  // repeat bit patterns, rpt5 in bit 4 down to rpt1 in bit 0
  localparam logic [4:0] RTCW_RPT_SEC = 5'h1f;
  localparam logic [4:0] RTCW_RPT_MIN = 5'h1e;
  localparam logic [4:0] RTCW_RPT_HOUR = 5'h1c;
  localparam logic [4:0] RTCW_RPT_DAY = 5'h18;
  localparam logic [4:0] RTCW_RPT_MONTH = 5'h10;
  localparam logic [4:0] RTCW_RPT_YEAR = 5'h00;

  typedef struct packed {
    logic chip_sel_n;
    logic write_n;
    logic out_drv_n;
    logic sram_pick_n;
    logic [RTCW_ADDR_W-1:0] addr;
    logic [RTCW_DATA_W-1:0] data;
  } rtcw_pins_t;

  localparam rtcw_pins_t RTCW_PINS_IDLE = '{1'b1, 1'b1, 1'b1, 1'b1, 4'h0, 8'h00};

  typedef struct packed {
    logic strobe;
    logic [RTCW_ADDR_W-1:0] addr;
    logic [RTCW_DATA_W-1:0] data;
  } rtcw_wr_t;

endpackage

//--- core/rtcw_alarm_rate.sv
// alarm repeat rate decode
// assumes repeat bits already gathered, rpt5 in the top bit
module rtcw_alarm_rate
  import rtcw_pkg::*;
(
  input wire logic [4:0] i_alarm_repeat_bits,
  output rtcw_pkg::rtcw_rate_t o_rate
);
  import rtcw_pkg::*;

  always_comb
  begin
    unique case (i_alarm_repeat_bits)
      RTCW_RPT_SEC: o_rate = RTCW_RATE_SEC;
      RTCW_RPT_MIN: o_rate = RTCW_RATE_MIN;
      RTCW_RPT_HOUR: o_rate = RTCW_RATE_HOUR;
      RTCW_RPT_DAY: o_rate = RTCW_RATE_DAY;
      RTCW_RPT_MONTH: o_rate = RTCW_RATE_MONTH;
      // undefined codes fall back to the slowest rate
      default: o_rate = RTCW_RATE_YEAR;
    endcase
  end

endmodule

//--- test/rtcw_host_model.sv
// host processor model driving the sram style pins of the write port
// assumes the bench calls its tasks; pins change 2 ns after a rising edge
module rtcw_host_model
(
  input wire logic i_clock,
  output rtcw_pkg::rtcw_pins_t o_pins
);
  timeunit 1ns;
  timeprecision 1ns;
  import rtcw_pkg::*;

  initial o_pins = RTCW_PINS_IDLE;

  task automatic step(input int n);
    repeat (n) @(posedge i_clock);
    #2;
  endtask

  task automatic set_ad(input logic [3:0] a, input logic [7:0] d);
    o_pins.addr = a;
    o_pins.data = d;
  endtask

  task automatic drive(input logic e, input logic w, input logic g, input logic x, input int n);
    o_pins.chip_sel_n = e;
    o_pins.write_n = w;
    o_pins.out_drv_n = g;
    o_pins.sram_pick_n = x;
    step(n);
  endtask

  // mode 0: strobe ends first, 1: select ends first, 2: both fall together
  task automatic wr(input logic [3:0] a, input logic [7:0] d0, input logic [7:0] d1,
                    input int mode);
    set_ad(a, d0);
    if (mode != 2)
      drive(1'b1, 1'b0, 1'b1, 1'b1, 2);
    drive(1'b0, 1'b0, 1'b1, 1'b1, 2);
    o_pins.data = d1;
    step(3);
    drive(mode == 1, mode != 1, 1'b1, 1'b1, 2);
    // released bus shows garbage, not the last byte
    o_pins.data = ~d1;
    drive(1'b1, 1'b1, 1'b1, 1'b1, 4);
  endtask
endmodule

//--- test/testbench.sv
// self-checking bench for the host write port and alarm repeat decode
// assumes one 25 mhz clock; the host model drives every pin
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import rtcw_pkg::*;
`define CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin err_total++; \
  $display("[FAIL] %0t got %h want %h", $time, got, exp); end end

  logic i_clock = 1'b0;
  logic i_resetn = 1'b0;
  rtcw_pins_t pins;
  logic [7:0] o_dq;
  logic o_dq_oe;
  logic o_sram_sel_n;
  logic o_contention;
  rtcw_wr_t o_wr;
  rtcw_rate_t o_alarm_rate;
  int err_total = 0;
  int num_checks = 0;
  logic [11:0] exp_q[$];
  logic [11:0] exp_w;
  logic [7:0] regs[16] = '{default: 8'h00};
  logic [4:0] codes[7] = '{5'h1f, 5'h1e, 5'h1c, 5'h18, 5'h10, 5'h00, 5'h0a};
  rtcw_rate_t rates[7] = '{RTCW_RATE_SEC, RTCW_RATE_MIN, RTCW_RATE_HOUR, RTCW_RATE_DAY,
                           RTCW_RATE_MONTH, RTCW_RATE_YEAR, RTCW_RATE_YEAR};

  always #20 i_clock = ~i_clock;

  rtcw_host_model host (.i_clock(i_clock), .o_pins(pins));

  rtcw_host_port DUT (.i_clock(i_clock), .i_resetn(i_resetn),
    .i_chip_sel_n(pins.chip_sel_n), .i_write_n(pins.write_n),
    .i_out_drv_n(pins.out_drv_n), .i_sram_pick_n(pins.sram_pick_n),
    .i_addr(pins.addr), .i_dq(pins.data), .o_dq(o_dq), .o_dq_oe(o_dq_oe),
    .o_sram_sel_n(o_sram_sel_n), .o_contention(o_contention), .o_wr(o_wr),
    .o_alarm_rate(o_alarm_rate));

  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic note_wr(input logic [3:0] a, input logic [7:0] d0, input logic [7:0] d1,
                         input int m);
    exp_q.push_back({a, d1});
    regs[a] = d1;
    host.wr(a, d0, d1, m);
  endtask

  // a strobe with nothing noted means a stray internal write
  always @(negedge i_clock)
    if (o_wr.strobe === 1'b1)
    begin
      `CHK(exp_q.size() > 0, 1'b1)
      if (exp_q.size() > 0)
      begin
        exp_w = exp_q.pop_front();
        `CHK({o_wr.addr, o_wr.data}, exp_w)
      end
    end

  initial
  begin
    #800000;
    err_total++;
    stop_test();
  end

  initial
  begin
    int seed;
    logic [31:0] r;
    logic [4:0] c;
    seed = 32'hdd8b3dd6;
    host.step(5);
    `CHK(o_dq_oe, 1'b0)
    `CHK(o_sram_sel_n, 1'b1)
    `CHK(o_alarm_rate, RTCW_RATE_YEAR)
    i_resetn = 1'b1;
    host.step(2);
    for (int i = 0; i < 12; i++)
    begin
      r = $random(seed);
      note_wr(r[3:0], r[11:4], r[19:12], i % 3);
    end
    $display("random writes done");
    for (int i = 0; i < 7; i++)
    begin
      r = $random(seed);
      c = codes[i];
      note_wr(RTCW_OFS_ASEC, {c[0], r[6:0]}, {c[0], r[6:0]}, 0);
      note_wr(RTCW_OFS_AMIN, {c[1], r[13:7]}, {c[1], r[13:7]}, 1);
      note_wr(RTCW_OFS_AHOUR, {c[2], r[20:14]}, {c[2], r[20:14]}, 2);
      note_wr(RTCW_OFS_ADATE, {c[3], c[4], r[26:21]}, {c[3], c[4], r[26:21]}, 0);
      `CHK(o_alarm_rate, rates[i])
    end
    $display("alarm rate done");
    // read drive, then a falling strobe must turn the outputs off
    r = $random(seed);
    host.set_ad(r[3:0], r[11:4]);
    host.drive(1'b0, 1'b1, 1'b0, 1'b1, 4);
    `CHK(o_dq_oe, 1'b1)
    `CHK(o_dq, regs[r[3:0]])
    exp_q.push_back({r[3:0], r[11:4]});
    regs[r[3:0]] = r[11:4];
    host.drive(1'b0, 1'b0, 1'b0, 1'b1, 4);
    `CHK(o_dq_oe, 1'b0)
    host.drive(1'b1, 1'b1, 1'b1, 1'b1, 5);
    // select and strobe fall together with drive low: never enabled
    host.set_ad(r[19:16], r[27:20]);
    exp_q.push_back({r[19:16], r[27:20]});
    regs[r[19:16]] = r[27:20];
    host.drive(1'b0, 1'b0, 1'b0, 1'b1, 0);
    repeat (6)
    begin
      host.step(1);
      `CHK(o_dq_oe, 1'b0)
    end
    // strobe back up with select and drive still low: must stay quiet
    host.drive(1'b0, 1'b1, 1'b0, 1'b1, 4);
    `CHK(o_dq_oe, 1'b0)
    host.drive(1'b1, 1'b1, 1'b1, 1'b1, 5);
    $display("output drive done");
    // sram write and a both-selects-low cycle
    host.drive(1'b1, 1'b0, 1'b1, 1'b0, 4);
    `CHK(o_sram_sel_n, 1'b0)
    host.drive(1'b1, 1'b1, 1'b1, 1'b1, 4);
    host.drive(1'b0, 1'b1, 1'b1, 1'b0, 4);
    `CHK(o_contention, 1'b1)
    `CHK(o_sram_sel_n, 1'b1)
    host.drive(1'b1, 1'b1, 1'b1, 1'b1, 4);
    `CHK(o_contention, 1'b0)
    `CHK(exp_q.size(), 0)
    $display("routing done");
    stop_test();
  end
endmodule
